/* logic/ppsm_pkg.sv */
package ppsm_pkg;

	// register indices on the plain register port
	localparam logic [1:0] ADDR_UART1_INPUT_ROUTE   = 2'h0;
	localparam logic [1:0] ADDR_PWM_AUX_INPUT_ROUTE = 2'h1;
	localparam logic [1:0] ADDR_OUTPUT_ROUTE_70_71  = 2'h2;
	localparam logic [1:0] ADDR_OUTPUT_ROUTE_79_80  = 2'h3;

	localparam int IN_SEL_W   = 7;
	localparam int OUT_SEL_W  = 6;
	localparam int REG_W      = 16;
	localparam int NUM_FUNC   = 64;
	localparam int NUM_SRC    = 128;

	// field positions (low bit of each field)
	localparam int IN_HI_LSB  = 8;
	localparam int IN_LO_LSB  = 0;
	localparam int OUT_HI_LSB = 8;
	localparam int OUT_LO_LSB = 0;

	// writable bits of each register kind; the rest read zero
	localparam logic [15:0] IN_REG_MASK  = 16'h7F7F;
	localparam logic [15:0] OUT_REG_MASK = 16'h3F3F;

	localparam logic [15:0] ROUTE_RESET = 16'h0000;

	localparam logic [6:0] SRC_GROUND     = 7'h00;
	localparam logic [6:0] SRC_COMPARATOR = 7'h01;
	localparam logic [6:0] SRC_PIN_127    = 7'h7F;

	typedef struct packed {
		logic [1:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ppsm_bus_req_t;

	typedef struct packed {
		logic [6:0] uart1_cts_source_sel;
		logic [6:0] uart1_rx_source_sel;
		logic [6:0] deadtime_comp1_source_sel;
		logic [6:0] pwm_sync2_source_sel;
		logic [5:0] pin71_function_sel;
		logic [5:0] pin70_function_sel;
		logic [5:0] pin80_function_sel;
		logic [5:0] pin79_function_sel;
	} ppsm_sel_t;

	typedef struct packed {
		logic uart1_clear_to_send_in;
		logic uart1_receive_in;
		logic deadtime_comp1_in;
		logic pwm_sync2_in;
	} ppsm_periph_in_t;

endpackage

/* logic/ppsm_in_sel.sv */
`timescale 1ns/1ps
module ppsm_in_sel
	import ppsm_pkg::*;
(
	input  wire logic [6:0]   sel,
	input  wire logic [127:0] remappable_io_pin,
	input  wire logic         comparator_one_output,
	output logic              routed
);
	// codes 2..127 pick the pin of that number
	wire logic pin_bit;
	assign pin_bit = remappable_io_pin[sel];
	assign routed  = (sel == SRC_GROUND)     ? 1'b0 :
	                 (sel == SRC_COMPARATOR) ? comparator_one_output :
	                 pin_bit;
endmodule

/* logic/ppsm_out_sel.sv */
`timescale 1ns/1ps
module ppsm_out_sel
	import ppsm_pkg::*;
(
	input  wire logic [5:0]  sel,
	input  wire logic [63:0] periph_func_out,
	output logic             pin_level,
	output logic             pin_driven
);
	// function 0 means no peripheral owns the pin
	assign pin_level  = periph_func_out[sel];
	assign pin_driven = (sel != 6'h00);
endmodule

/* logic/ppsm_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - uart1 cts input from reg0 bits 14-8
// - uart1 rx input from reg0 bits 6-0
// - all-ones code selects pin 127
// - code one selects comparator 1 output
// - code zero ties input low
// - deadtime comp input from reg1 bits 14-8
// - pwm sync2 input from reg1 bits 6-0
// - pin 71 function from reg2 bits 13-8
// - pin 70 function from reg2 bits 5-0
// - pin 80 function from reg3 bits 13-8
// - pin 79 function from reg3 bits 5-0
// - unused bits read zero, ignore writes
module ppsm_top
	import ppsm_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic [1:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [15:0]           reg_rdata,
	input  wire logic [127:0]          remappable_io_pin,
	input  wire logic                  comparator_one_output,
	input  wire logic [63:0]           periph_func_out,
	output ppsm_periph_in_t            periph_in,
	output logic      [3:0]            pin_out_level,
	output logic      [3:0]            pin_out_en,
	output ppsm_sel_t                  sel_view
);
	logic [15:0] route_q [4];
	logic [15:0] route_d [4];
	logic [15:0] rdata_d;
	ppsm_bus_req_t req;
	ppsm_sel_t     sel;
	ppsm_periph_in_t in_d;
	ppsm_periph_in_t in_q;
	logic [3:0]  lvl_d;
	logic [3:0]  en_d;
	logic [3:0]  lvl_q;
	logic [3:0]  en_q;

	function automatic logic [15:0] reg_mask(input logic [1:0] idx);
		reg_mask = (idx == ADDR_OUTPUT_ROUTE_70_71 || idx == ADDR_OUTPUT_ROUTE_79_80) ?
		           OUT_REG_MASK : IN_REG_MASK;
	endfunction

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_reg
			assign route_d[gi] = (req.wr && req.addr == 2'(gi)) ?
			                     (req.wdata & reg_mask(2'(gi))) : route_q[gi];
			always_ff @(posedge core_clk) begin
				if (reset) begin
					route_q[gi] <= ROUTE_RESET;
				end else begin
					route_q[gi] <= route_d[gi];
				end
			end
		end
	endgenerate

	// masked storage makes unused bits read zero
	assign rdata_d = req.rd ? route_q[req.addr] : 16'h0000;

	assign sel.uart1_cts_source_sel =
		route_q[ADDR_UART1_INPUT_ROUTE][IN_HI_LSB +: IN_SEL_W];
	assign sel.uart1_rx_source_sel =
		route_q[ADDR_UART1_INPUT_ROUTE][IN_LO_LSB +: IN_SEL_W];
	assign sel.deadtime_comp1_source_sel =
		route_q[ADDR_PWM_AUX_INPUT_ROUTE][IN_HI_LSB +: IN_SEL_W];
	assign sel.pwm_sync2_source_sel =
		route_q[ADDR_PWM_AUX_INPUT_ROUTE][IN_LO_LSB +: IN_SEL_W];
	assign sel.pin71_function_sel =
		route_q[ADDR_OUTPUT_ROUTE_70_71][OUT_HI_LSB +: OUT_SEL_W];
	assign sel.pin70_function_sel =
		route_q[ADDR_OUTPUT_ROUTE_70_71][OUT_LO_LSB +: OUT_SEL_W];
	assign sel.pin80_function_sel =
		route_q[ADDR_OUTPUT_ROUTE_79_80][OUT_HI_LSB +: OUT_SEL_W];
	assign sel.pin79_function_sel =
		route_q[ADDR_OUTPUT_ROUTE_79_80][OUT_LO_LSB +: OUT_SEL_W];

	ppsm_in_sel u_cts (
		.sel                   (sel.uart1_cts_source_sel),
		.remappable_io_pin     (remappable_io_pin),
		.comparator_one_output (comparator_one_output),
		.routed                (in_d.uart1_clear_to_send_in)
	);
	ppsm_in_sel u_rx (
		.sel                   (sel.uart1_rx_source_sel),
		.remappable_io_pin     (remappable_io_pin),
		.comparator_one_output (comparator_one_output),
		.routed                (in_d.uart1_receive_in)
	);
	ppsm_in_sel u_dtc (
		.sel                   (sel.deadtime_comp1_source_sel),
		.remappable_io_pin     (remappable_io_pin),
		.comparator_one_output (comparator_one_output),
		.routed                (in_d.deadtime_comp1_in)
	);
	ppsm_in_sel u_sync (
		.sel                   (sel.pwm_sync2_source_sel),
		.remappable_io_pin     (remappable_io_pin),
		.comparator_one_output (comparator_one_output),
		.routed                (in_d.pwm_sync2_in)
	);

	// pin order: [0]=70 [1]=71 [2]=79 [3]=80
	ppsm_out_sel u_p70 (
		.sel             (sel.pin70_function_sel),
		.periph_func_out (periph_func_out),
		.pin_level       (lvl_d[0]),
		.pin_driven      (en_d[0])
	);
	ppsm_out_sel u_p71 (
		.sel             (sel.pin71_function_sel),
		.periph_func_out (periph_func_out),
		.pin_level       (lvl_d[1]),
		.pin_driven      (en_d[1])
	);
	ppsm_out_sel u_p79 (
		.sel             (sel.pin79_function_sel),
		.periph_func_out (periph_func_out),
		.pin_level       (lvl_d[2]),
		.pin_driven      (en_d[2])
	);
	ppsm_out_sel u_p80 (
		.sel             (sel.pin80_function_sel),
		.periph_func_out (periph_func_out),
		.pin_level       (lvl_d[3]),
		.pin_driven      (en_d[3])
	);

	// outputs registered: one cycle of latency traded for clean timing
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
			in_q      <= '0;
			lvl_q     <= 4'h0;
			en_q      <= 4'h0;
			sel_view  <= '0;
		end else begin
			reg_rdata <= rdata_d;
			in_q      <= in_d;
			lvl_q     <= lvl_d;
			en_q      <= en_d;
			sel_view  <= sel;
		end
	end

	assign periph_in     = in_q;
	assign pin_out_level = lvl_q;
	assign pin_out_en    = en_q;
endmodule

/* verif/ppsm_partner.sv */
`timescale 1ns/1ps
module ppsm_partner (
	input wire logic	core_clk,
	output logic [127:0]	remappable_io_pin,
	output logic	comparator_one_output,
	output logic [63:0]	periph_func_out
);
	// levels move every cycle so a stale route cannot match by luck
	logic [192:0]	s_q = {1'b1, {4{48'hA5C3_96E1_0F3D}}};
	always @(posedge core_clk) s_q <= {s_q[191:0], s_q[192] ^ s_q[150]};
	assign {comparator_one_output, periph_func_out, remappable_io_pin} = s_q;
endmodule

/* verif/ppsm_top_chk.sv */
`timescale 1ns/1ps
module ppsm_top_chk
	import ppsm_pkg::*;
(
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic [1:0]	reg_addr,
	input wire logic [15:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [15:0]	reg_rdata,
	input wire logic [127:0]	remappable_io_pin,
	input wire logic	comparator_one_output,
	input wire logic [63:0]	periph_func_out,
	input wire ppsm_periph_in_t	periph_in,
	input wire logic [3:0]	pin_out_level,
	input wire logic [3:0]	pin_out_en,
	input wire ppsm_sel_t	sel_view
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// routed outputs lag their sources by one edge
	logic [127:0]	pin_q;
	logic [63:0]	func_q;
	always_ff @(posedge core_clk) begin
		pin_q <= remappable_io_pin;
		func_q <= periph_func_out;
	end
	unused_zero_a: assert property (
		$past(reg_rd) |-> !(reg_rdata & ~($past(reg_addr[1]) ? OUT_REG_MASK : IN_REG_MASK)))
		else $error("unused bit set");
	cts_write_a: assert property (
		reg_wr && reg_addr == ADDR_UART1_INPUT_ROUTE |-> ##2
		sel_view.uart1_cts_source_sel == $past(reg_wdata[14:8], 2)) else $error("cts lost");
	rx_ground_a: assert property (
		sel_view.uart1_rx_source_sel == SRC_GROUND |-> !periph_in.uart1_receive_in)
		else $error("rx not low");
	cts_comp_a: assert property (
		sel_view.uart1_cts_source_sel == SRC_COMPARATOR |->
		periph_in.uart1_clear_to_send_in == $past(comparator_one_output)) else $error("cts bad");
	dt_pin127_a: assert property (
		sel_view.deadtime_comp1_source_sel == SRC_PIN_127 |->
		periph_in.deadtime_comp1_in == pin_q[127]) else $error("dt bad");
	sync_pin_a: assert property (
		sel_view.pwm_sync2_source_sel > 7'h01 |->
		periph_in.pwm_sync2_in == pin_q[sel_view.pwm_sync2_source_sel]) else $error("sync bad");
	out_enable_a: assert property (
		pin_out_en[3] == |sel_view.pin80_function_sel && pin_out_en[0] == |sel_view.pin70_function_sel)
		else $error("enable bad");
	pin71_level_a: assert property (
		pin_out_en[1] |-> pin_out_level[1] == func_q[sel_view.pin71_function_sel])
		else $error("pin71 bad");
	pin79_level_a: assert property (
		pin_out_en[2] |-> pin_out_level[2] == func_q[sel_view.pin79_function_sel])
		else $error("pin79 bad");
endmodule
bind ppsm_top ppsm_top_chk chk_u (.*);

/* verif/ppsm_top_tb.sv */
`timescale 1ns/1ps
module ppsm_top_tb
	import ppsm_pkg::*;
;
	logic	core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, comparator_one_output, pc, prd;
	logic [1:0]	reg_addr = 0;
	logic [15:0]	reg_wdata = 0, reg_rdata, erd, m[4], pm[4];
	logic [127:0]	remappable_io_pin, pp;
	logic [63:0]	periph_func_out, pf;
	logic [3:0]	pin_out_level, pin_out_en, ee;
	ppsm_periph_in_t	periph_in;
	ppsm_sel_t	sel_view;
	int	n_errors = 0, checks_done = 0, cyc = 0, i;
	ppsm_partner prt_u (.*);
	ppsm_top dut_u (.*);
	always #10 core_clk = ~core_clk;
	task automatic results;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 2000) begin
			n_errors++;
			results;
		end
	end
	task automatic chk(input logic [127:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	function automatic logic src(logic [6:0] s);
		return s < 7'h02 ? s[0] & pc : pp[s];
	endfunction
	// codes 0, 1 and all-ones are biased in; plain random rarely hits them
	function automatic logic [7:0] fld();
		logic [31:0] r;
		r = $urandom;
		return {r[9], r[1:0] == 2'h3 ? r[16:10] : r[1] ? 7'h7F : {6'h00, r[0]}};
	endfunction
	task automatic op(logic [1:0] k, logic [1:0] a, logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= k[0];
		reg_rd <= k[1];
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	// model runs on the falling edge, one cycle behind what it predicts
	always @(negedge core_clk) begin
		if (!reset) begin
			chk(reg_rdata, prd ? erd : 16'h0000);
			chk(periph_in, {src(pm[0][14:8]), src(pm[0][6:0]), src(pm[1][14:8]), src(pm[1][6:0])});
			chk(sel_view, {pm[0][14:8], pm[0][6:0], pm[1][14:8], pm[1][6:0], pm[2][13:8],
				pm[2][5:0], pm[3][13:8], pm[3][5:0]});
			ee = {|pm[3][13:8], |pm[3][5:0], |pm[2][13:8], |pm[2][5:0]};
			chk(pin_out_en, ee);
			chk(pin_out_level & ee, {pf[pm[3][13:8]], pf[pm[3][5:0]], pf[pm[2][13:8]], pf[pm[2][5:0]]} & ee);
		end
		// clear before the snapshot: first compare after reset expects zeros
		if (reset) m = '{default: 16'h0000};
		erd = m[reg_addr];
		prd = reg_rd && !reset;
		pm = m;
		pp = remappable_io_pin;
		pc = comparator_one_output;
		pf = periph_func_out;
		if (!reset && reg_wr) m[reg_addr] = reg_wdata & (reg_addr[1] ? OUT_REG_MASK : IN_REG_MASK);
	end
	initial begin
		i = $urandom(57055);
		repeat (2) begin
			reset <= 1;
			repeat (2) @(posedge core_clk);
			reset <= 0;
			for (i = 0; i < 4; i++) op(2'h2, 2'(i), 16'h0000);
			repeat (400) op(2'($urandom % 3), 2'($urandom), {fld(), fld()});
			op(2'h0, 2'h0, 16'h0000);
		end
		repeat (3) @(posedge core_clk);
		results;
	end
endmodule
